// ---- hdl/tmr_pkg.sv ----
// shared constants and types for the dual timer/counter with external request logic
package tmr_pkg;

  // special function register addresses
  localparam logic [7:0] ADDR_CONTROL   = 8'h88;
  localparam logic [7:0] ADDR_MODE      = 8'h89;
  localparam logic [7:0] ADDR_T0_LOW    = 8'h8a;
  localparam logic [7:0] ADDR_T1_LOW    = 8'h8b;
  localparam logic [7:0] ADDR_T0_HIGH   = 8'h8c;
  localparam logic [7:0] ADDR_T1_HIGH   = 8'h8d;

  // reset values
  localparam logic [7:0] RST_CONTROL    = 8'h00;
  localparam logic [7:0] RST_MODE       = 8'h00;
  localparam logic [7:0] RST_COUNT      = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // control register bit positions
  localparam int BIT_OVF_T1 = 7;
  localparam int BIT_RUN_T1 = 6;
  localparam int BIT_OVF_T0 = 5;
  localparam int BIT_RUN_T0 = 4;
  localparam int BIT_REQ_B  = 3;
  localparam int BIT_TRIG_B = 2;
  localparam int BIT_REQ_A  = 1;
  localparam int BIT_TRIG_A = 0;

  // mode register field positions
  localparam int BIT_GATE1 = 7;
  localparam int BIT_CT1   = 6;
  localparam int POS_MODE1 = 4;
  localparam int BIT_GATE0 = 3;
  localparam int BIT_CT0   = 2;
  localparam int POS_MODE0 = 0;

  // width of the low part of the 13-bit count
  localparam int LOW13_W = 5;
  localparam logic [4:0] LOW13_MAX = 5'h1f;
  localparam logic [7:0] BYTE_MAX  = 8'hff;

  // acknowledge / request vector positions
  localparam int REQ_EXT_A = 0;
  localparam int REQ_T0    = 1;
  localparam int REQ_EXT_B = 2;
  localparam int REQ_T1    = 3;

  typedef enum logic [1:0] {
    MODE_13BIT  = 2'b00,
    MODE_16BIT  = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT  = 2'b11
  } mode_field_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       we;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
    logic       ovf;
  } count_step_t;

endpackage

// ---- hdl/ext_request_flag.sv ----
// one external interrupt request flag with edge or level detection
module ext_request_flag
  import tmr_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic trigger_edge_i,
  input  wire logic pin_n_i,
  input  wire logic ack_i,
  input  wire logic sw_we_i,
  input  wire logic sw_val_i,
  output logic      flag_o
);

  typedef struct packed {
    logic pin_q;
    logic flag;
  } flag_state_t;

  flag_state_t st_r;
  flag_state_t st_nxt;
  logic        fall;

  always_comb begin
    st_nxt       = st_r;
    st_nxt.pin_q = pin_n_i;
    fall         = st_r.pin_q & ~pin_n_i;
    if (trigger_edge_i) begin
      st_nxt.flag = sw_we_i ? sw_val_i : (st_r.flag & ~ack_i);
      if (fall) begin
        st_nxt.flag = 1'b1;
      end
    end else begin
      st_nxt.flag = ~pin_n_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      // pin idles high so no false edge right after reset
      st_r <= '{pin_q: 1'b1, flag: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flag_o = st_r.flag;

endmodule

// ---- hdl/dual_timer.sv ----
// two timer/counters with four modes plus external request flags
module dual_timer
  import tmr_pkg::*;
(
  input  wire logic       CLOCK_I,
  input  wire logic       SRST_I,
  input  wire sfr_req_t   SFR_REQ_I,
  output logic [7:0]      SFR_RDATA_O,
  input  wire logic       COUNT_INPUT_PIN_A_I,
  input  wire logic       COUNT_INPUT_PIN_B_I,
  input  wire logic       EXT_IRQ_PIN_A_N_I,
  input  wire logic       EXT_IRQ_PIN_B_N_I,
  input  wire logic [3:0] VECTOR_ACK_I,
  output logic [3:0]      IRQ_REQ_O,
  output logic            T1_OVERFLOW_O
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  // run bits, overflow flags and the read word sit beside the counts so that
  // a single register stage holds all but the external request flags and their pin history, which sit in their flag modules

  typedef struct packed {
    logic [7:0] t0_hi;
    logic [7:0] t0_lo;
    logic [7:0] t1_hi;
    logic [7:0] t1_lo;
    logic [7:0] mode_reg;
    logic       run_bit_t0;
    logic       run_bit_t1;
    logic       overflow_flag_t0;
    logic       overflow_flag_t1;
    logic       ext_trigger_type_a;
    logic       ext_trigger_type_b;
    logic       pin_a_q;
    logic       pin_b_q;
    logic [7:0] rdata;
    logic       t1_ovf_pulse;
  } timer_state_t;

  timer_state_t st_r;
  timer_state_t st_nxt;

  logic [1:0]  ext_flag;
  logic [1:0]  ext_pin_n;
  logic [1:0]  ext_edge;
  logic [1:0]  ext_ack;
  logic [1:0]  ext_sw_val;
  logic        we_ctrl;

  ////////////////////////////////////////////////////////////////////////////
  // one counting step of a timer in the given mode

  function automatic count_step_t count_step(input mode_field_t mode,
                                             input logic [7:0]  hi,
                                             input logic [7:0]  lo,
                                             input logic        tick);
    count_step_t r;
    r.hi  = hi;
    r.lo  = lo;
    r.ovf = 1'b0;
    if (tick) begin
      unique case (mode)
        // thirteen bit count
        // upper three low bits keep what software wrote
        MODE_13BIT: begin
          r.lo[LOW13_W-1:0] = lo[LOW13_W-1:0] + 5'h01;
          if (lo[LOW13_W-1:0] == LOW13_MAX) begin
            r.hi  = hi + 8'h01;
            r.ovf = (hi == BYTE_MAX);
          end
        end
        MODE_16BIT: begin
          r.lo = lo + 8'h01;
          if (lo == BYTE_MAX) begin
            r.hi  = hi + 8'h01;
            r.ovf = (hi == BYTE_MAX);
          end
        end
        MODE_RELOAD: begin
          r.lo  = (lo == BYTE_MAX) ? hi : lo + 8'h01;
          r.ovf = (lo == BYTE_MAX);
        end
        // low byte alone, high byte handled by caller
        MODE_SPLIT: begin
          r.lo  = lo + 8'h01;
          r.ovf = (lo == BYTE_MAX);
        end
      endcase
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic        gate0;
    logic        gate1;
    logic        ct0;
    logic        ct1;
    mode_field_t mode0;
    mode_field_t mode1;
    logic        fall_a;
    logic        fall_b;
    logic        tick0;
    logic        tick1;
    logic        tick0_hi;
    logic        split0;
    logic        ovf0_hi;
    logic        set_tf0;
    logic        set_tf1;
    logic        en0;
    logic        en1;
    logic        run1;
    count_step_t s0;
    count_step_t s1;

    // every local gets a value first, so none can look like a latch
    // and no pass ever reads a value left from an earlier pass
    gate0    = 1'b0;
    gate1    = 1'b0;
    ct0      = 1'b0;
    ct1      = 1'b0;
    mode0    = MODE_13BIT;
    mode1    = MODE_13BIT;
    fall_a   = 1'b0;
    fall_b   = 1'b0;
    tick0    = 1'b0;
    tick1    = 1'b0;

    tick0_hi = 1'b0;
    split0   = 1'b0;
    ovf0_hi  = 1'b0;
    set_tf0  = 1'b0;
    set_tf1  = 1'b0;
    en0      = 1'b0;
    en1      = 1'b0;
    run1     = 1'b0;
    s0       = '0;
    s1       = '0;

    st_nxt   = st_r;
    gate0    = st_r.mode_reg[BIT_GATE0];
    gate1    = st_r.mode_reg[BIT_GATE1];
    ct0      = st_r.mode_reg[BIT_CT0];
    ct1      = st_r.mode_reg[BIT_CT1];
    mode0    = mode_field_t'(st_r.mode_reg[POS_MODE0 +: 2]);
    mode1    = mode_field_t'(st_r.mode_reg[POS_MODE1 +: 2]);
    split0   = (mode0 == MODE_SPLIT);

    st_nxt.pin_a_q = COUNT_INPUT_PIN_A_I;
    st_nxt.pin_b_q = COUNT_INPUT_PIN_B_I;
    fall_a   = st_r.pin_a_q & ~COUNT_INPUT_PIN_A_I;
    fall_b   = st_r.pin_b_q & ~COUNT_INPUT_PIN_B_I;

    en0      = st_r.run_bit_t0 & (~gate0 | EXT_IRQ_PIN_A_N_I);
    // split timer 0 takes the run bit, timer 1 then runs on its mode
    run1     = st_r.run_bit_t1 | split0;
    en1      = run1 & (~gate1 | EXT_IRQ_PIN_B_N_I);

    tick0    = en0 & (ct0 ? fall_a : 1'b1);
    tick1    = en1 & (ct1 ? fall_b : 1'b1) & (mode1 != MODE_SPLIT);
    // split high byte uses timer 1 run
    tick0_hi = split0 & st_r.run_bit_t1;

    // both timers step every clock; the ticks decide whether they move
    s0 = count_step(mode0, st_r.t0_hi, st_r.t0_lo, tick0);
    s1 = count_step(mode1, st_r.t1_hi, st_r.t1_lo, tick1);

    st_nxt.t0_lo = s0.lo;
    st_nxt.t0_hi = s0.hi;
    ovf0_hi      = 1'b0;
    if (split0) begin
      st_nxt.t0_hi = tick0_hi ? st_r.t0_hi + 8'h01 : st_r.t0_hi;
      ovf0_hi      = tick0_hi & (st_r.t0_hi == BYTE_MAX);
    end
    st_nxt.t1_lo = s1.lo;
    st_nxt.t1_hi = s1.hi;

    // software writes to the counts win over counting in the same cycle
    we_ctrl = SFR_REQ_I.we & (SFR_REQ_I.addr == ADDR_CONTROL);
    if (SFR_REQ_I.we) begin
      unique case (SFR_REQ_I.addr)
        ADDR_T0_LOW:  st_nxt.t0_lo    = SFR_REQ_I.wdata;
        ADDR_T0_HIGH: st_nxt.t0_hi    = SFR_REQ_I.wdata;
        ADDR_T1_LOW:  st_nxt.t1_lo    = SFR_REQ_I.wdata;
        ADDR_T1_HIGH: st_nxt.t1_hi    = SFR_REQ_I.wdata;
        ADDR_MODE:    st_nxt.mode_reg = SFR_REQ_I.wdata;
        default: ;
      endcase
    end

    // run write leaves counts alone
    // request flag bits of the word go to the flag modules instead
    if (we_ctrl) begin
      st_nxt.run_bit_t0         = SFR_REQ_I.wdata[BIT_RUN_T0];
      st_nxt.run_bit_t1         = SFR_REQ_I.wdata[BIT_RUN_T1];
      st_nxt.ext_trigger_type_a = SFR_REQ_I.wdata[BIT_TRIG_A];
      st_nxt.ext_trigger_type_b = SFR_REQ_I.wdata[BIT_TRIG_B];
    end

    // timer 1 loses its flag in split
    set_tf0 = s0.ovf;
    set_tf1 = split0 ? ovf0_hi : s1.ovf;

    if (we_ctrl) begin
      st_nxt.overflow_flag_t0 = SFR_REQ_I.wdata[BIT_OVF_T0];
      st_nxt.overflow_flag_t1 = SFR_REQ_I.wdata[BIT_OVF_T1];
    end else begin
      st_nxt.overflow_flag_t0 = st_r.overflow_flag_t0 & ~VECTOR_ACK_I[REQ_T0];
      st_nxt.overflow_flag_t1 = st_r.overflow_flag_t1 & ~VECTOR_ACK_I[REQ_T1];
    end
    if (set_tf0) begin
      st_nxt.overflow_flag_t0 = 1'b1;
    end
    if (set_tf1) begin
      st_nxt.overflow_flag_t1 = 1'b1;
    end

    // baud-rate tick keeps running from timer 1 in every mode but its own mode 3
    st_nxt.t1_ovf_pulse = s1.ovf;

    // registered read, one cycle behind the address
    unique case (SFR_REQ_I.addr)
      ADDR_CONTROL: st_nxt.rdata = {st_r.overflow_flag_t1,
                                    st_r.run_bit_t1,
                                    st_r.overflow_flag_t0,
                                    st_r.run_bit_t0,
                                    ext_flag[1],
                                    st_r.ext_trigger_type_b,
                                    ext_flag[0],
                                    st_r.ext_trigger_type_a};
      ADDR_MODE:    st_nxt.rdata = st_r.mode_reg;
      ADDR_T0_LOW:  st_nxt.rdata = st_r.t0_lo;
      ADDR_T0_HIGH: st_nxt.rdata = st_r.t0_hi;
      ADDR_T1_LOW:  st_nxt.rdata = st_r.t1_lo;
      ADDR_T1_HIGH: st_nxt.rdata = st_r.t1_hi;
      default:      st_nxt.rdata = RDATA_UNMAPPED;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      // count bytes cleared
      // count pin history starts high so a pin still high at release is no edge
      st_r <= '{t0_hi:              RST_COUNT,
                t0_lo:              RST_COUNT,
                t1_hi:              RST_COUNT,
                t1_lo:              RST_COUNT,
                mode_reg:           RST_MODE,
                run_bit_t0:         RST_CONTROL[BIT_RUN_T0],
                run_bit_t1:         RST_CONTROL[BIT_RUN_T1],
                overflow_flag_t0:   RST_CONTROL[BIT_OVF_T0],
                overflow_flag_t1:   RST_CONTROL[BIT_OVF_T1],
                ext_trigger_type_a: RST_CONTROL[BIT_TRIG_A],
                ext_trigger_type_b: RST_CONTROL[BIT_TRIG_B],
                pin_a_q:            1'b1,
                pin_b_q:            1'b1,
                rdata:              RDATA_UNMAPPED,
                t1_ovf_pulse:       1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external request flags

  assign ext_pin_n  = {EXT_IRQ_PIN_B_N_I, EXT_IRQ_PIN_A_N_I};
  assign ext_edge   = {st_r.ext_trigger_type_b, st_r.ext_trigger_type_a};
  assign ext_ack    = {VECTOR_ACK_I[REQ_EXT_B], VECTOR_ACK_I[REQ_EXT_A]};
  assign ext_sw_val = {SFR_REQ_I.wdata[BIT_REQ_B], SFR_REQ_I.wdata[BIT_REQ_A]};

  // each pin keeps its own edge history inside its flag module

  for (genvar g = 0; g < 2; g++) begin : g_ext
    ext_request_flag u_flag (
      .clk_i          (CLOCK_I),
      .srst_i         (SRST_I),
      .trigger_edge_i (ext_edge[g]),
      .pin_n_i        (ext_pin_n[g]),
      .ack_i          (ext_ack[g]),
      .sw_we_i        (we_ctrl),
      .sw_val_i       (ext_sw_val[g]),
      .flag_o         (ext_flag[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign SFR_RDATA_O   = st_r.rdata;
  assign T1_OVERFLOW_O = st_r.t1_ovf_pulse;
  // every request bit is a flop, here or in a flag module
  assign IRQ_REQ_O     = {st_r.overflow_flag_t1,
                          ext_flag[1],
                          st_r.overflow_flag_t0,
                          ext_flag[0]};

endmodule

// ---- bench/dual_timer_props.sv ----
// concurrent checks on the dual timer ports
module dual_timer_props
  import tmr_pkg::*;
(
  input wire logic       CLOCK_I,
  input wire logic       SRST_I,
  input wire sfr_req_t   SFR_REQ_I,
  input wire logic [7:0] SFR_RDATA_O,
  input wire logic       EXT_IRQ_PIN_A_N_I,
  input wire logic [3:0] VECTOR_ACK_I,
  input wire logic [3:0] IRQ_REQ_O,
  input wire logic       T1_OVERFLOW_O
);
  logic       wr_ctl;
  logic [7:0] ctl_r;
  logic [7:0] mode_r;
  assign wr_ctl = SFR_REQ_I.we && SFR_REQ_I.addr == ADDR_CONTROL;
  // mirror of software bits; flag bits of ctl_r are never used
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      ctl_r  <= RST_CONTROL;
      mode_r <= RST_MODE;
    end else begin
      if (wr_ctl) ctl_r <= SFR_REQ_I.wdata;
      if (SFR_REQ_I.we && SFR_REQ_I.addr == ADDR_MODE) mode_r <= SFR_REQ_I.wdata;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (SRST_I);
  chk_level_follows_pin: assert property (
    !ctl_r[BIT_TRIG_A] |=> IRQ_REQ_O[REQ_EXT_A] == !$past(EXT_IRQ_PIN_A_N_I))
    else $error("level flag does not follow pin");
  chk_edge_sets_flag: assert property (
    ctl_r[BIT_TRIG_A] && $past(EXT_IRQ_PIN_A_N_I) && !EXT_IRQ_PIN_A_N_I
    |=> IRQ_REQ_O[REQ_EXT_A])
    else $error("falling edge missed");
  chk_edge_ack_clears: assert property (
    ctl_r[BIT_TRIG_A] && VECTOR_ACK_I[REQ_EXT_A] && EXT_IRQ_PIN_A_N_I && !wr_ctl
    |=> !IRQ_REQ_O[REQ_EXT_A])
    else $error("edge flag kept after ack");
  chk_ovf_ack_clears: assert property (
    !ctl_r[BIT_RUN_T0] && VECTOR_ACK_I[REQ_T0] && !wr_ctl |=> !IRQ_REQ_O[REQ_T0])
    else $error("overflow flag kept after ack");
  chk_stopped_flag_holds: assert property (
    !ctl_r[BIT_RUN_T1] && !VECTOR_ACK_I[REQ_T1] && !wr_ctl |=> $stable(IRQ_REQ_O[REQ_T1]))
    else $error("flag moved while stopped");
  chk_pulse_needs_run: assert property (
    T1_OVERFLOW_O |-> $past(ctl_r[BIT_RUN_T1]) || $past(ctl_r[BIT_RUN_T1], 2)
    || $past(mode_r[POS_MODE0 +: 2]) == MODE_SPLIT)
    else $error("overflow pulse while stopped");
  chk_mode_readback: assert property (
    SFR_REQ_I.addr == ADDR_MODE |=> SFR_RDATA_O == $past(mode_r))
    else $error("mode readback wrong");
  chk_ctl_readback: assert property (
    SFR_REQ_I.addr == ADDR_CONTROL |=> (SFR_RDATA_O & 8'h55) == ($past(ctl_r) & 8'h55))
    else $error("control readback wrong");
endmodule

bind dual_timer dual_timer_props u_props (
  .CLOCK_I(CLOCK_I), .SRST_I(SRST_I), .SFR_REQ_I(SFR_REQ_I), .SFR_RDATA_O(SFR_RDATA_O),
  .EXT_IRQ_PIN_A_N_I(EXT_IRQ_PIN_A_N_I), .VECTOR_ACK_I(VECTOR_ACK_I),
  .IRQ_REQ_O(IRQ_REQ_O), .T1_OVERFLOW_O(T1_OVERFLOW_O));

// ---- bench/core_vector_model.sv ----
// core that vectors to enabled pending requests after a set wait
module core_vector_model (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic [3:0] req_i,
  input  wire logic [3:0] enable_i,
  input  wire logic [3:0] wait_i,
  output logic [3:0]      ack_o
);
  logic [3:0] wait_r;
  logic [3:0] pend;
  assign pend = req_i & enable_i & ~ack_o;
  always_ff @(posedge clk_i) begin
    if (srst_i || pend == 4'h0) begin
      wait_r <= 4'h0;
      ack_o  <= 4'h0;
    end else if (wait_r < wait_i) begin
      wait_r <= wait_r + 4'h1;
      ack_o  <= 4'h0;
    end else begin
      wait_r <= 4'h0;
      // one vector at a time, lowest pending first
      ack_o  <= pend & ~(pend - 4'h1);
    end
  end
endmodule

// ---- bench/tb_dual_timer.sv ----
// self-checking bench for the dual timer block
module tb_dual_timer
  import tmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk;
  logic       srst;
  sfr_req_t   req;
  logic [7:0] rdata;
  logic [1:0] cnt_pin;
  logic [1:0] irq_n;
  logic [3:0] ack;
  logic [3:0] irq;
  logic [3:0] en;
  logic [3:0] lat;
  logic       t1_ovf;
  int         num_errors;
  int         tests_run;
  dual_timer dut (.CLOCK_I(clk), .SRST_I(srst), .SFR_REQ_I(req), .SFR_RDATA_O(rdata),
    .COUNT_INPUT_PIN_A_I(cnt_pin[0]), .COUNT_INPUT_PIN_B_I(cnt_pin[1]),
    .EXT_IRQ_PIN_A_N_I(irq_n[0]), .EXT_IRQ_PIN_B_N_I(irq_n[1]),
    .VECTOR_ACK_I(ack), .IRQ_REQ_O(irq), .T1_OVERFLOW_O(t1_ovf));
  core_vector_model core (.clk_i(clk), .srst_i(srst), .req_i(irq), .enable_i(en),
    .wait_i(lat), .ack_o(ack));
  ////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, we: 1'b1, wdata: d};
    @(posedge clk);
    req.we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    req.addr <= a;
    @(posedge clk);
    #1 check(rdata, exp);
  endtask
  task automatic reset_values();
    wr(8'h90, 8'hff);
    for (int a = 8'h88; a <= 8'h8e; a++) begin
      rd(8'(a), 8'h00);
    end
  endtask
  // two enabled cycles, then stop; overflow falls on the stopping edge
  task automatic run_case(input int t, input logic [7:0] run, md, hi, lo, ehi, elo,
                          input logic ef);
    wr(ADDR_MODE, md);
    wr(t ? ADDR_T1_HIGH : ADDR_T0_HIGH, hi);
    wr(t ? ADDR_T1_LOW : ADDR_T0_LOW, lo);
    wr(ADDR_CONTROL, run);
    wr(ADDR_CONTROL, 8'h00);
    #1 check(8'(irq[2*t+1]), 8'(ef));
    rd(t ? ADDR_T1_HIGH : ADDR_T0_HIGH, ehi);
    rd(t ? ADDR_T1_LOW : ADDR_T0_LOW, elo);
  endtask
  task automatic timer_modes();
    run_case(0, 8'h10, 8'h01, 8'hff, 8'hfe, 8'h00, 8'h00, 1);
    @(posedge clk);
    en <= 4'h2;
    repeat (6) @(posedge clk);
    #1 check(8'(irq[1]), 8'h00);
    @(posedge clk);
    en <= 4'h0;
    run_case(0, 8'h10, 8'h00, 8'hff, 8'hfe, 8'h00, 8'he0, 1);
    run_case(0, 8'h10, 8'h02, 8'h80, 8'hfe, 8'h80, 8'h80, 1);
    run_case(1, 8'h40, 8'h10, 8'h12, 8'h34, 8'h12, 8'h36, 0);
    run_case(1, 8'h40, 8'h20, 8'h7f, 8'hfe, 8'h7f, 8'h7f, 1);
    run_case(1, 8'h40, 8'h30, 8'h12, 8'h34, 8'h12, 8'h34, 0);
    run_case(0, 8'h50, 8'h03, 8'hfe, 8'hfe, 8'h00, 8'h00, 1);
    check(8'(irq[3]), 8'h01);
    irq_n[0] <= 1'b0;
    run_case(0, 8'h10, 8'h09, 8'h12, 8'h34, 8'h12, 8'h34, 0);
    irq_n[0] <= 1'b1;
    run_case(0, 8'h10, 8'h09, 8'hff, 8'hfe, 8'h00, 8'h00, 1);
  endtask
  // split timer 0 leaves timer 1 running on its mode, pulses but no flag
  task automatic baud_split();
    int n;
    n = 0;
    wr(ADDR_MODE, 8'h33);
    wr(ADDR_T1_HIGH, 8'hf0);
    wr(ADDR_T1_LOW, 8'hf0);
    wr(ADDR_MODE, 8'h23);
    repeat (64) begin
      @(posedge clk);
      #1 if (t1_ovf) n++;
    end
    check(8'(n), 8'h04);
    check(8'(irq[3]), 8'h00);
    n = 0;
    wr(ADDR_MODE, 8'h33);
    repeat (40) begin
      @(posedge clk);
      #1 if (t1_ovf) n++;
    end
    check(8'(n), 8'h00);
  endtask
  task automatic count_pins();
    wr(ADDR_MODE, 8'h05);
    wr(ADDR_T0_LOW, 8'h00);
    wr(ADDR_CONTROL, 8'h10);
    repeat (3) begin
      repeat (2) @(posedge clk);
      cnt_pin[0] <= 1'b0;
      repeat (2) @(posedge clk);
      cnt_pin[0] <= 1'b1;
    end
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_T0_LOW, 8'h03);
  endtask
  task automatic ext_case(input int b);
    wr(ADDR_CONTROL, b ? 8'h04 : 8'h01);
    irq_n[b] <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check(8'(irq[2*b]), 8'h01);
    @(posedge clk);
    irq_n[b] <= 1'b1;
    en[2*b] <= 1'b1;
    repeat (6) @(posedge clk);
    #1 check(8'(irq[2*b]), 8'h00);
    wr(ADDR_CONTROL, 8'h00);
    irq_n[b] <= 1'b0;
    repeat (6) @(posedge clk);
    #1 check(8'(irq[2*b]), 8'h01);
    @(posedge clk);
    irq_n[b] <= 1'b1;
    en <= 4'h0;
    repeat (3) @(posedge clk);
    #1 check(8'(irq[2*b]), 8'h00);
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    complete_run();
  end
  initial begin
    srst = 1'b1;
    req = '0;
    cnt_pin = 2'b11;
    irq_n = 2'b11;
    en = 4'h0;
    lat = 4'h2;
    num_errors = 0;
    tests_run = 0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    reset_values();
    timer_modes();
    baud_split();
    count_pins();
    ext_case(0);
    ext_case(1);
    complete_run();
  end
endmodule
